// file: shared/mcc_pkg.sv
/*
 Register map, field layout, mode encoding and timing counts for the
 main clock controller with time base and beeper.
 Assumes pclk is the oscillator clock and paddr carries byte addresses.
*/
package mcc_pkg;

   localparam int unsigned CLK_HZ = 20_000_000;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_CTRL_STATUS = 8'h2C;
   localparam logic [7:0] IDX_BEEP        = 8'h2D;
   localparam logic [7:0] IDX_IRQ_STATUS  = 8'h2E;
   localparam logic [7:0] IDX_IRQ_MASK    = 8'h2F;
   localparam int unsigned ADDR_W         = 10;
   localparam logic [ADDR_W-1:0] ADDR_CTRL_STATUS = {IDX_CTRL_STATUS, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_BEEP        = {IDX_BEEP, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS  = {IDX_IRQ_STATUS, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK    = {IDX_IRQ_MASK, 2'b00};

   localparam logic [7:0] CS_RESET    = 8'h00;
   localparam logic [1:0] TONE_RESET  = 2'h0;
   localparam logic [1:0] TONE_OFF    = 2'h0;
   localparam logic       IRQ_RESET   = 1'b0;
   localparam int unsigned IRQ_TICK_BIT = 0;

   // time base prescaler counts in oscillator cycles
   localparam int unsigned TB_W    = 18;
   localparam int unsigned TB_DIV0 = 16000;
   localparam int unsigned TB_DIV1 = 32000;
   localparam int unsigned TB_DIV2 = 80000;
   localparam int unsigned TB_DIV3 = 200000;

   // tone frequencies in Hz and their periods in pclk cycles
   localparam int unsigned BEEP_HZ1     = 2000;
   localparam int unsigned BEEP_HZ2     = 1000;
   localparam int unsigned BEEP_HZ3     = 500;
   localparam int unsigned BEEP_PERIOD1 = CLK_HZ / BEEP_HZ1;
   localparam int unsigned BEEP_PERIOD2 = CLK_HZ / BEEP_HZ2;
   localparam int unsigned BEEP_PERIOD3 = CLK_HZ / BEEP_HZ3;

   typedef enum logic [1:0] {
      MCC_RUN      = 2'b00,
      MCC_WAIT     = 2'b01,
      MCC_ACT_HALT = 2'b10,
      MCC_HALT     = 2'b11
   } mcc_mode_type;

   // bit 7 down to bit 0 of the control/status register
   typedef struct packed {
      logic       clock_out_enable;
      logic [1:0] slow_divider_select;
      logic       slow_select;
      logic [1:0] timebase_select;
      logic       tick_irq_enable;
      logic       tick_flag;
   } mcc_ctrl_type;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0]       pwdata;
   } mcc_apb_req_type;

   typedef struct packed {
      mcc_mode_type   mode;
      mcc_ctrl_type   cs;
      logic [1:0]     tone_select;
      logic           irq_status;
      logic           irq_mask;
      logic [1:0]     tb_active;
      logic [TB_W-1:0] tb_cnt;
      logic [3:0]     pre_cnt;
      logic [TB_W-1:0] beep_cnt;
      logic           tone_pin;
      logic           core_clk_en;
      logic           clk_out_run;
      logic [31:0]    prdata;
      logic           rd_tick;
   } mcc_state_type;

endpackage

// file: rtl/mcc_main_clock_ctrl.sv
/*
 Main clock controller: slow-mode core clock prescaler, clock-out gating,
 time-base counter with tick flag and interrupt, beeper, power-mode tracking,
 APB register slave.
 Assumes pclk is the oscillator clock; halt_req, wait_req, ext_wake and
 cpu_irq_masked come from logic on pclk; the chip combines clock_out_run
 with its clock onto the clock-out pin.
*/
// What this block does
// - core clock is osc clock, or divided by 2,4,8,16 in slow mode
// - clock-out enable routes clock to its pin, else pin is plain I/O
// - clock-out suspended during active-halt even when enabled
// - time base divides osc clock by 16000/32000/80000/200000, timeout each period
// - new time-base selection takes effect only at end of running period
// - hardware sets tick flag at period end; reading control/status clears it
// - interrupt requested only with tick enable set and cpu mask inactive
// - halt with tick enable set enters active-halt instead of halt
// - tick interrupt wakes wait and active-halt, never full halt
// - wait mode leaves counters and outputs running
// - active-halt keeps time base running, registers hold
// - halt freezes counter and registers until a halt-capable wake
// - tone select: off, ~2 kHz, ~1 kHz, ~500 Hz square waves
// - beeper keeps running during active-halt
// - prescaler, clock-out and time base work independently together
// - all four registers reset to zero
`timescale 1ns/1ps
module mcc_main_clock_ctrl #(
   parameter int unsigned TB_DIV0      = mcc_pkg::TB_DIV0,
   parameter int unsigned TB_DIV1      = mcc_pkg::TB_DIV1,
   parameter int unsigned TB_DIV2      = mcc_pkg::TB_DIV2,
   parameter int unsigned TB_DIV3      = mcc_pkg::TB_DIV3,
   parameter int unsigned BEEP_PERIOD1 = mcc_pkg::BEEP_PERIOD1,
   parameter int unsigned BEEP_PERIOD2 = mcc_pkg::BEEP_PERIOD2,
   parameter int unsigned BEEP_PERIOD3 = mcc_pkg::BEEP_PERIOD3
) (
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire mcc_pkg::mcc_apb_req_type apb,
   output logic [31:0]                   prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic                     halt_req,
   input  wire logic                     wait_req,
   input  wire logic                     ext_wake,
   input  wire logic                     cpu_irq_masked,
   output logic                          irq,
   output logic                          core_clk_en,
   output logic                          clock_out_sel,
   output logic                          clock_out_run,
   output logic                          tone_port_pin,
   output mcc_pkg::mcc_mode_type         power_mode
);
   import mcc_pkg::*;

   mcc_state_type state_ff;
   mcc_state_type nxt_state;
   logic          tb_wrap;
   logic          access;
   logic          hit;
   logic          halted;
   logic          frozen;

   function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
      addr_hit = (a == ADDR_CTRL_STATUS) || (a == ADDR_BEEP) ||
                 (a == ADDR_IRQ_STATUS) || (a == ADDR_IRQ_MASK);
   endfunction

   // last count of the slow prescaler: 1, 3, 7, 15
   function automatic logic [3:0] div_top(input logic [1:0] code);
      div_top = 4'((5'h2 << code) - 5'h1);
   endfunction

   function automatic logic [TB_W-1:0] tb_top(input logic [1:0] code);
      case (code)
         2'h0:    tb_top = TB_W'(TB_DIV0 - 1);
         2'h1:    tb_top = TB_W'(TB_DIV1 - 1);
         2'h2:    tb_top = TB_W'(TB_DIV2 - 1);
         default: tb_top = TB_W'(TB_DIV3 - 1);
      endcase
   endfunction

   // last count of a half tone period
   function automatic logic [TB_W-1:0] beep_top(input logic [1:0] code);
      case (code)
         2'h1:    beep_top = TB_W'(BEEP_PERIOD1 / 2 - 1);
         2'h2:    beep_top = TB_W'(BEEP_PERIOD2 / 2 - 1);
         default: beep_top = TB_W'(BEEP_PERIOD3 / 2 - 1);
      endcase
   endfunction

   assign access  = apb.psel && apb.penable;
   assign hit     = addr_hit(apb.paddr);
   assign halted  = (state_ff.mode == MCC_ACT_HALT) || (state_ff.mode == MCC_HALT);
   assign frozen  = (state_ff.mode == MCC_HALT);
   assign tb_wrap = !frozen && (state_ff.tb_cnt >= tb_top(state_ff.tb_active));

   always_comb begin
      nxt_state = state_ff;

      // core clock prescaler; stops in both halt modes
      if (halted) begin
         nxt_state.core_clk_en = 1'b0;
      end else if (state_ff.cs.slow_select) begin
         if (state_ff.pre_cnt >= div_top(state_ff.cs.slow_divider_select)) begin
            nxt_state.pre_cnt     = 4'h0;
            nxt_state.core_clk_en = 1'b1;
         end else begin
            nxt_state.pre_cnt     = state_ff.pre_cnt + 4'h1;
            nxt_state.core_clk_en = 1'b0;
         end
      end else begin
         nxt_state.pre_cnt     = 4'h0;
         nxt_state.core_clk_en = 1'b1;
      end

      // time base keeps running in wait and active-halt
      if (tb_wrap) begin
         nxt_state.tb_cnt    = '0;
         nxt_state.tb_active = state_ff.cs.timebase_select;
      end else if (!frozen) begin
         nxt_state.tb_cnt = state_ff.tb_cnt + TB_W'(1);
      end

      // beeper, alive in active-halt
      if (!frozen) begin
         if (state_ff.tone_select == TONE_OFF) begin
            nxt_state.beep_cnt = '0;
            nxt_state.tone_pin = 1'b0;
         end else if (state_ff.beep_cnt >= beep_top(state_ff.tone_select)) begin
            nxt_state.beep_cnt = '0;
            nxt_state.tone_pin = !state_ff.tone_pin;
         end else begin
            nxt_state.beep_cnt = state_ff.beep_cnt + TB_W'(1);
         end
      end

      // read data is captured in the setup phase
      if (apb.psel && !apb.penable) begin
         nxt_state.prdata  = 32'h0000_0000;
         nxt_state.rd_tick = 1'b0;
         if (!apb.pwrite) begin
            case (apb.paddr)
               ADDR_CTRL_STATUS: begin
                  nxt_state.prdata  = {24'h00_0000, state_ff.cs};
                  nxt_state.rd_tick = state_ff.cs.tick_flag;
               end
               ADDR_BEEP:       nxt_state.prdata = {30'h0000_0000, state_ff.tone_select};
               ADDR_IRQ_STATUS: nxt_state.prdata = {31'h0000_0000, state_ff.irq_status};
               ADDR_IRQ_MASK:   nxt_state.prdata = {31'h0000_0000, state_ff.irq_mask};
               default:         nxt_state.prdata = 32'h0000_0000;
            endcase
         end
      end

      // writes and read side effects blocked while halted
      if (access && !halted) begin
         if (apb.pwrite) begin
            case (apb.paddr)
               ADDR_CTRL_STATUS: begin
                  nxt_state.cs           = mcc_ctrl_type'(apb.pwdata[7:0]);
                  nxt_state.cs.tick_flag = state_ff.cs.tick_flag;
               end
               ADDR_BEEP:       nxt_state.tone_select = apb.pwdata[1:0];
               ADDR_IRQ_STATUS: begin
                  if (apb.pwdata[IRQ_TICK_BIT]) begin
                     nxt_state.irq_status = 1'b0;
                  end
               end
               ADDR_IRQ_MASK:   nxt_state.irq_mask = apb.pwdata[IRQ_TICK_BIT];
               default:         nxt_state.irq_mask = state_ff.irq_mask;
            endcase
         end else if (apb.paddr == ADDR_CTRL_STATUS && state_ff.rd_tick) begin
            nxt_state.cs.tick_flag = 1'b0;
         end
      end

      // hardware set wins over a clear in the same cycle
      if (tb_wrap) begin
         nxt_state.cs.tick_flag = 1'b1;
         nxt_state.irq_status   = 1'b1;
      end

      case (state_ff.mode)
         MCC_RUN: begin
            if (halt_req) begin
               nxt_state.mode = state_ff.cs.tick_irq_enable ? MCC_ACT_HALT : MCC_HALT;
            end else if (wait_req) begin
               nxt_state.mode = MCC_WAIT;
            end
         end
         MCC_WAIT: begin
            if (irq || ext_wake) begin
               nxt_state.mode = MCC_RUN;
            end
         end
         MCC_ACT_HALT: begin
            if (irq || ext_wake) begin
               nxt_state.mode = MCC_RUN;
            end
         end
         MCC_HALT: begin
            if (ext_wake) begin
               nxt_state.mode = MCC_RUN;
            end
         end
         default: nxt_state.mode = MCC_RUN;
      endcase

      nxt_state.clk_out_run = nxt_state.cs.clock_out_enable &&
                              ((nxt_state.mode == MCC_RUN) ||
                               (nxt_state.mode == MCC_WAIT));
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff             <= '0;
         state_ff.mode        <= MCC_RUN;
         state_ff.cs          <= mcc_ctrl_type'(CS_RESET);
         state_ff.tone_select <= TONE_RESET;
         state_ff.irq_status  <= IRQ_RESET;
         state_ff.irq_mask    <= IRQ_RESET;
         state_ff.core_clk_en <= 1'b1;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign prdata        = state_ff.prdata;
   assign pready        = 1'b1;
   assign pslverr       = access && !hit;
   assign irq           = state_ff.irq_status && state_ff.irq_mask &&
                          state_ff.cs.tick_irq_enable && !cpu_irq_masked;
   assign core_clk_en   = state_ff.core_clk_en;
   assign clock_out_sel = state_ff.cs.clock_out_enable;
   assign clock_out_run = state_ff.clk_out_run;
   assign tone_port_pin = state_ff.tone_pin;
   assign power_mode    = state_ff.mode;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_tick_sets_flag: assert property (tb_wrap |=> state_ff.cs.tick_flag)
      else $error("tick flag not set at period end");

   a_read_clears_flag: assert property (
      (access && !apb.pwrite && apb.paddr == ADDR_CTRL_STATUS && !halted &&
       state_ff.rd_tick && !tb_wrap) |=> !state_ff.cs.tick_flag)
      else $error("tick flag survived a read");

   a_tb_switch_at_end: assert property (
      (state_ff.tb_active != $past(state_ff.tb_active)) |-> $past(tb_wrap))
      else $error("time base switched mid period");

   a_tb_wrap_count: assert property (
      tb_wrap |-> state_ff.tb_cnt == tb_top(state_ff.tb_active))
      else $error("time base period length wrong");

   a_slow_pulse_gap: assert property (
      (state_ff.cs.slow_select && !halted && state_ff.pre_cnt != 4'h0 &&
       state_ff.cs.slow_divider_select == $past(state_ff.cs.slow_divider_select))
      |-> !$past(core_clk_en) || $past(state_ff.pre_cnt) == 4'h0)
      else $error("slow prescaler pulse out of place");

   a_full_speed: assert property (
      (!state_ff.cs.slow_select && !halted)[*2] |-> core_clk_en)
      else $error("core clock stalled in normal mode");

   a_clkout_suspend: assert property (
      (state_ff.mode == MCC_ACT_HALT) |-> !clock_out_run)
      else $error("clock out active in active-halt");

   a_act_halt_entry: assert property (
      (state_ff.mode == MCC_RUN && halt_req && state_ff.cs.tick_irq_enable)
      |=> state_ff.mode == MCC_ACT_HALT)
      else $error("halt did not enter active-halt");

   a_halt_holds: assert property (
      (state_ff.mode == MCC_HALT && !ext_wake) |=> state_ff.mode == MCC_HALT)
      else $error("halt left without external wake");

   a_halt_frozen: assert property (
      (state_ff.mode == MCC_HALT) |=> $stable(state_ff.tb_cnt) && $stable(state_ff.cs))
      else $error("counter or registers moved in halt");

   a_act_halt_regs: assert property (
      (state_ff.mode == MCC_ACT_HALT) |=>
      $stable(state_ff.tone_select) && $stable(state_ff.cs.timebase_select))
      else $error("registers changed in active-halt");

   a_irq_gate: assert property (
      irq |-> state_ff.cs.tick_irq_enable && !cpu_irq_masked)
      else $error("interrupt without enable");

   a_beep_off: assert property (
      (state_ff.tone_select == TONE_OFF && !frozen) |=> !tone_port_pin)
      else $error("beeper active while off");

   c_act_halt_wake: cover property (
      state_ff.mode == MCC_ACT_HALT ##1 state_ff.mode == MCC_RUN);
   c_halt_ext_wake: cover property (
      state_ff.mode == MCC_HALT ##1 state_ff.mode == MCC_RUN);
   c_tick_read: cover property (state_ff.cs.tick_flag ##[1:20] !state_ff.cs.tick_flag);
   c_tone_toggle: cover property ($rose(tone_port_pin));

endmodule

// file: testbench/test_mcc_main_clock_ctrl.sv
/*
 Self-checking bench for the main clock controller: registers over APB,
 core clock prescaler, time base, beeper and power modes.
 Assumes mcc_pkg is compiled first; short counts come from parameters.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
   $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); end end

module test_mcc_main_clock_ctrl;
   import mcc_pkg::*;
   // shortened counts so every period fits in a short run
   localparam int SH_TB0 = 16;
   localparam int SH_TB1 = 32;
   localparam int SH_TB2 = 80;
   localparam int SH_TB3 = 200;
   localparam int SH_BP1 = 8;
   localparam int SH_BP2 = 16;
   localparam int SH_BP3 = 32;
   localparam int dv[4] = '{SH_TB0, SH_TB1, SH_TB2, SH_TB3};
   localparam int bp[4] = '{0, SH_BP1, SH_BP2, SH_BP3};

   logic            pclk = 1'b0;
   logic            presetn = 1'b0;
   logic            halt_req = 1'b0;
   logic            wait_req = 1'b0;
   logic            ext_wake = 1'b0;
   logic            cpu_irq_masked = 1'b0;
   mcc_apb_req_type req = '0;
   logic [31:0]     prdata;
   logic [31:0]     q;
   logic            pready;
   logic            pslverr;
   logic            e;
   logic            irq;
   logic            core_clk_en;
   logic            clock_out_sel;
   logic            clock_out_run;
   logic            tone_port_pin;
   mcc_mode_type    power_mode;
   logic [1:0]      mon;
   int              error_cnt = 0;
   int              n_tests = 0;
   int              cyc = 0;
   int              a, b, p, old, k, c;

   assign mon = {tone_port_pin, irq};

   mcc_main_clock_ctrl #(
      .TB_DIV0(SH_TB0), .TB_DIV1(SH_TB1), .TB_DIV2(SH_TB2), .TB_DIV3(SH_TB3),
      .BEEP_PERIOD1(SH_BP1), .BEEP_PERIOD2(SH_BP2), .BEEP_PERIOD3(SH_BP3)
   ) mcc_main_clock_ctrl_i (
      .pclk(pclk), .presetn(presetn), .apb(req), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .halt_req(halt_req), .wait_req(wait_req), .ext_wake(ext_wake),
      .cpu_irq_masked(cpu_irq_masked), .irq(irq), .core_clk_en(core_clk_en),
      .clock_out_sel(clock_out_sel), .clock_out_run(clock_out_run),
      .tone_port_pin(tone_port_pin), .power_mode(power_mode)
   );

   always #25 pclk = ~pclk;

   always @(posedge pclk) begin
      cyc <= cyc + 1;
   end

   task automatic conclude();
      $display("checks %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // one APB transfer; read data and error land in q and e
   task automatic apb(input logic w, input logic [ADDR_W-1:0] ad, input logic [31:0] d);
      int i;
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: ad, pwdata: d};
      @(posedge pclk);
      req.penable <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 50) begin
         error_cnt++;
         conclude();
      end
      q = prdata;
      e = pslverr;
      req <= '0;
   endtask

   // s = 0: rise of irq, s = 1: any toggle of the tone pin
   task automatic wait_ev(input int s, output int at);
      logic v;
      int   i;
      v = mon[s];
      at = -1;
      for (i = 0; i < 3000 && at < 0; i++) begin
         @(negedge pclk);
         if (mon[s] !== v && (s == 1 || mon[s] === 1'b1)) at = cyc;
         v = mon[s];
      end
      if (at < 0) begin
         error_cnt++;
         conclude();
      end
   endtask

   task automatic stable(input int n, output int ch);
      logic v;
      ch = 0;
      v = tone_port_pin;
      repeat (n) begin
         @(negedge pclk);
         if (tone_port_pin !== v) ch++;
         v = tone_port_pin;
      end
   endtask

   task automatic pulse(input logic [2:0] m);
      @(posedge pclk);
      {ext_wake, wait_req, halt_req} <= m;
      @(posedge pclk);
      {ext_wake, wait_req, halt_req} <= 3'h0;
   endtask

   initial begin
      #5_000_000;
      error_cnt++;
      conclude();
   end

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      `CHK({core_clk_en, clock_out_sel, clock_out_run, tone_port_pin}, 4'h8)
      `CHK(power_mode, MCC_RUN)
      for (k = 0; k < 4; k++) begin
         apb(1'b0, ADDR_CTRL_STATUS + ADDR_W'(4 * k), '0);
         `CHK(q, 32'h0)
      end
      apb(1'b0, 10'h000, '0);
      `CHK({e, q}, 33'h100000000)
      $display("test reset done");

      apb(1'b1, ADDR_BEEP, 32'h3);
      apb(1'b0, ADDR_BEEP, '0);
      `CHK(q, 32'h3)
      for (k = 1; k < 4; k++) begin
         apb(1'b1, ADDR_BEEP, 32'(k));
         wait_ev(1, p);
         wait_ev(1, a);
         wait_ev(1, b);
         `CHK({a - p, b - a}, {bp[k] / 2, bp[k] / 2})
      end
      apb(1'b1, ADDR_BEEP, '0);
      repeat (2) @(negedge pclk);
      stable(40, c);
      `CHK({c, tone_port_pin}, {32'd0, 1'b0})
      $display("test beeper done");

      for (k = 0; k < 5; k++) begin
         apb(1'b1, ADDR_CTRL_STATUS, (k < 4) ? 32'(16 | (k << 5)) : 32'h0);
         repeat (20) @(negedge pclk);
         c = 0;
         repeat (64) begin
            @(negedge pclk);
            if (core_clk_en === 1'b1) c++;
         end
         `CHK(c, (k < 4) ? (32 >> k) : 64)
      end
      $display("test prescaler done");

      apb(1'b1, ADDR_IRQ_MASK, 32'h1);
      apb(1'b1, ADDR_CTRL_STATUS, 32'h2);
      apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
      wait_ev(0, p);
      apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
      old = 0;
      for (k = 1; k < 5; k++) begin
         apb(1'b1, ADDR_CTRL_STATUS, 32'(2 + 4 * (k % 4)));
         wait_ev(0, a);
         `CHK(a - p, dv[old])
         apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
         wait_ev(0, b);
         `CHK(b - a, dv[k % 4])
         apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
         p = b;
         old = k % 4;
      end
      cpu_irq_masked <= 1'b1;
      repeat (20) @(negedge pclk);
      `CHK(irq, 1'b0)
      @(posedge pclk);
      cpu_irq_masked <= 1'b0;
      @(negedge pclk);
      `CHK(irq, 1'b1)
      apb(1'b1, ADDR_IRQ_MASK, 32'h0);
      @(negedge pclk);
      `CHK(irq, 1'b0)
      apb(1'b1, ADDR_IRQ_MASK, 32'h1);
      apb(1'b0, ADDR_IRQ_MASK, '0);
      `CHK(q, 32'h1)
      apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
      wait_ev(0, p);
      apb(1'b1, ADDR_CTRL_STATUS, 32'h0);
      apb(1'b0, ADDR_CTRL_STATUS, '0);
      `CHK(q, 32'h1)
      apb(1'b0, ADDR_CTRL_STATUS, '0);
      `CHK(q, 32'h0)
      repeat (10) @(negedge pclk);
      apb(1'b0, ADDR_CTRL_STATUS, '0);
      `CHK(q, 32'h1)
      `CHK(irq, 1'b0)
      $display("test time base done");

      apb(1'b1, ADDR_CTRL_STATUS, 32'h82);
      apb(1'b1, ADDR_BEEP, 32'h1);
      cpu_irq_masked <= 1'b1;
      apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
      repeat (2) @(negedge pclk);
      `CHK({clock_out_sel, clock_out_run}, 2'b11)
      pulse(3'b001);
      @(negedge pclk);
      `CHK(power_mode, MCC_ACT_HALT)
      @(negedge pclk);
      `CHK({clock_out_sel, clock_out_run, core_clk_en}, 3'b100)
      apb(1'b1, ADDR_BEEP, 32'h0);
      apb(1'b0, ADDR_BEEP, '0);
      `CHK(q, 32'h1)
      wait_ev(1, a);
      wait_ev(1, b);
      `CHK(b - a, bp[1] / 2)
      repeat (20) @(negedge pclk);
      apb(1'b0, ADDR_IRQ_STATUS, '0);
      `CHK({q, power_mode}, {32'h1, MCC_ACT_HALT})
      cpu_irq_masked <= 1'b0;
      repeat (3) @(negedge pclk);
      `CHK(power_mode, MCC_RUN)
      apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
      wait_ev(0, p);
      apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
      pulse(3'b010);
      repeat (2) @(negedge pclk);
      `CHK({power_mode, clock_out_run}, {MCC_WAIT, 1'b1})
      wait_ev(0, a);
      `CHK(a - p, dv[0])
      repeat (2) @(negedge pclk);
      `CHK(power_mode, MCC_RUN)
      apb(1'b1, ADDR_CTRL_STATUS, 32'h80);
      pulse(3'b001);
      repeat (2) @(negedge pclk);
      `CHK({power_mode, core_clk_en}, {MCC_HALT, 1'b0})
      stable(100, c);
      apb(1'b1, ADDR_BEEP, 32'h0);
      apb(1'b0, ADDR_BEEP, '0);
      `CHK({c, q, power_mode}, {32'd0, 32'h1, MCC_HALT})
      pulse(3'b100);
      repeat (2) @(negedge pclk);
      `CHK(power_mode, MCC_RUN)
      $display("test power modes done");
      conclude();
   end
endmodule
